// ---- inc/lei_cfg.svh ----
`ifndef LEI_CFG_SVH
`define LEI_CFG_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define LEI_IDX_MAINT_CTRL 10'h031
`define LEI_IDX_TERM_SEL 10'h032
`define LEI_IDX_IEN_LINE 10'h033
`define LEI_IDX_IEN_ERR 10'h034
`define LEI_IDX_EDGE_SEL 10'h035
`define LEI_IDX_LIVE_STAT 10'h036
`define LEI_IDX_PEND_LINE 10'h03a
`define LEI_IDX_PEND_ERR 10'h03b
`define LEI_IDX_CNT_HIGH 10'h03c
`define LEI_IDX_CNT_LOW 10'h03d

// ----------------------------------------
// Writable bit masks and reset values
// ----------------------------------------
`define LEI_MASK_MAINT 8'h03
`define LEI_MASK_TERM 8'h3f
`define LEI_MASK_LINE 8'h05
`define LEI_MASK_ERR 8'h77
`define LEI_RST_TERM 8'h07
`define LEI_RST_ZERO 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LEI_BIT_SNAP 0
`define LEI_BIT_MODE 1
`define LEI_BIT_LOSS 0
`define LEI_BIT_DRV 2
`define LEI_BIT_CNTOV 0
`define LEI_BIT_BPV 1
`define LEI_BIT_EXZ 2
`define LEI_BIT_RXJ 4
`define LEI_BIT_TXJ 5
`define LEI_BIT_TPL 6
`define LEI_TX_MSB 5
`define LEI_TX_LSB 3
`define LEI_RX_MSB 2
`define LEI_RX_LSB 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define LEI_CLK_PERIOD_NS 20
`define LEI_REPORT_PERIOD_NS 1000000000
`define LEI_SEC_W 26

`endif

// ---- inc/lei_pkg.sv ----
`include "lei_cfg.svh"

package lei_pkg;

	// ----------------------------------------
	// Bus handshake phase
	// ----------------------------------------
	typedef enum logic [0:0] {
		LEI_BUS_IDLE,
		LEI_BUS_ACK
	} lei_bus_e;

	// ----------------------------------------
	// Whole state of the controller
	// ----------------------------------------
	typedef struct packed {
		lei_bus_e bus;
		logic [31:0] dat;
		logic [2:0] drv_sync;
		logic [2:0] loss_sync;
		logic [7:0] maint;
		logic [7:0] term;
		logic [7:0] ien_line;
		logic [7:0] ien_err;
		logic [7:0] edge_sel;
		logic [7:0] live;
		logic [7:0] pend_line;
		logic [7:0] pend_err;
		logic [15:0] cnt_snap;
		logic [`LEI_SEC_W-1:0] sec_cnt;
		logic irq;
		logic [1:0] tx_code;
		logic tx_reserved;
		logic [1:0] rx_code;
		logic rx_bypass;
	} lei_state_s;

endpackage : lei_pkg

// ---- core/lei_line_event_ctrl.sv ----
// Summary of operation
// - Snapshot strobe acts only in manual report mode; auto mode ignores it.
// - Strobe rising edge copies 16-bit excess-zero count into high/low registers.
// - Tx termination 000=75,001=120,010=100,011=110 ohm; 1xx reserved.
// - Rx termination same codes; 1xx bypasses internal matching for external circuit.
// - Driver-fault pending bit 2 raises interrupt only when its enable is set.
// - Signal-loss pending bit 0 raises interrupt only when its enable is set.
// - Template-sum pending bit 6 raises interrupt only when its enable is set.
// - Tx jitter FIFO pending bit 5 raises interrupt only when enabled.
// - Rx jitter FIFO pending bit 4 raises interrupt only when enabled.
// - Excess-zero pending bit 2 raises interrupt only when enabled.
// - Bipolar violation pending bit 1 raises interrupt only when enabled.
// - Counter overflow pending bit 0 raises interrupt only when enabled.
// - Driver-fault pending sets on rise, or any change when edge select is one.
// - Signal-loss pending sets on rise, or any change when edge select is one.
// - Live driver-fault status at bit 2, read-only, resets to zero.
// - Live signal-loss status at bit 0, read-only, resets to zero.
// - Pending flags stay set until written one; writing zero leaves them.
// - Auto report mode copies the count into the registers once per second.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "lei_cfg.svh"

module lei_line_event_ctrl
	import lei_pkg::*;
#(
	parameter int unsigned REPORT_CYCLES = `LEI_REPORT_PERIOD_NS / `LEI_CLK_PERIOD_NS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Live line conditions from the analog front end
	input wire logic driver_fault_i,
	input wire logic signal_loss_i,
	// One-cycle event pulses from same-clock logic
	input wire logic template_sum_evt_i,
	input wire logic tx_jitter_fifo_evt_i,
	input wire logic rx_jitter_fifo_evt_i,
	input wire logic excess_zero_evt_i,
	input wire logic bipolar_violation_evt_i,
	input wire logic counter_overflow_evt_i,
	// Running excess-zero count from the error counter
	input wire logic [15:0] excess_zero_count_i,
	// Interrupt and termination controls
	output logic irq_o,
	output logic [1:0] tx_term_code_o,
	output logic tx_term_reserved_o,
	output logic [1:0] rx_term_code_o,
	output logic rx_term_bypass_o
);

	// ----------------------------------------
	// Constants
	// ----------------------------------------
	// Timer end point and termination reset image
	localparam logic [`LEI_SEC_W-1:0] SEC_LAST = `LEI_SEC_W'(REPORT_CYCLES - 1);
	localparam logic [7:0] TERM_RST = `LEI_RST_TERM; // Tx 75 ohm, rx bypassed

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Status change that latches a pending flag
	function automatic logic lei_edge_hit(
		input logic old_v,
		input logic new_v,
		input logic both
	);
		lei_edge_hit = both ? (old_v != new_v) : (!old_v && new_v);
	endfunction : lei_edge_hit

	// Stable level once the last two sync stages agree
	function automatic logic lei_filter(
		input logic [2:0] sync,
		input logic held
	);
		lei_filter = (sync[1] == sync[2]) ? sync[2] : held;
	endfunction : lei_filter

	// Masked byte write through lane 0
	function automatic logic [7:0] lei_wr(
		input logic [7:0] old_v,
		input logic [7:0] wdat,
		input logic [7:0] mask
	);
		lei_wr = (old_v & ~mask) | (wdat & mask);
	endfunction : lei_wr

	// Sticky flag update; a new event beats a same-cycle clear
	function automatic logic [7:0] lei_sticky(
		input logic [7:0] old_v,
		input logic [7:0] set_v,
		input logic [7:0] clr_v
	);
		lei_sticky = (old_v & ~clr_v) | set_v;
	endfunction : lei_sticky

	// Impedance code of a three-bit termination field
	function automatic logic [1:0] lei_term_code(
		input logic [2:0] field
	);
		lei_term_code = field[1:0];
	endfunction : lei_term_code

	// Upper bit of a termination field: reserved on tx, bypass on rx
	function automatic logic lei_term_upper(
		input logic [2:0] field
	);
		lei_term_upper = field[2];
	endfunction : lei_term_upper

	// ----------------------------------------
	// State
	// ----------------------------------------
	lei_state_s state_q;
	lei_state_s state_d;

	// Bus decode
	logic req;
	logic wr_en;
	logic [9:0] idx;
	logic [7:0] rdat;
	logic [7:0] wbyte;

	// Write strobes, one per writable register
	logic wr_maint;
	logic wr_term;
	logic wr_ien_line;
	logic wr_ien_err;
	logic wr_edge;
	logic wr_pend_line;
	logic wr_pend_err;

	// Filtered line levels
	logic drv_new;
	logic loss_new;

	// Counter report timing
	logic snap_rise;
	logic sec_tick;
	logic take_snap;

	// Flag set, clear and enable masks
	logic [7:0] clr_line;
	logic [7:0] clr_err;
	logic [7:0] set_line;
	logic [7:0] set_err;
	logic [7:0] en_line;
	logic [7:0] en_err;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		req = cyc_i && stb_i && (state_q.bus == LEI_BUS_IDLE);
		wr_en = req && we_i && sel_i[0];
		idx = adr_i[11:2];
		wbyte = dat_i[7:0];
		rdat = 8'h00;
		wr_maint = 1'b0;
		wr_term = 1'b0;
		wr_ien_line = 1'b0;
		wr_ien_err = 1'b0;
		wr_edge = 1'b0;
		wr_pend_line = 1'b0;
		wr_pend_err = 1'b0;

		// Synchronisers on the front-end levels
		state_d.drv_sync = {state_q.drv_sync[1:0], driver_fault_i};
		state_d.loss_sync = {state_q.loss_sync[1:0], signal_loss_i};
		drv_new = lei_filter(state_q.drv_sync, state_q.live[`LEI_BIT_DRV]);
		loss_new = lei_filter(state_q.loss_sync, state_q.live[`LEI_BIT_LOSS]);
		state_d.live = 8'h00;
		state_d.live[`LEI_BIT_DRV] = drv_new;
		state_d.live[`LEI_BIT_LOSS] = loss_new;

		// Register read mux
		if (idx == `LEI_IDX_MAINT_CTRL) begin
			rdat = state_q.maint;
		end else if (idx == `LEI_IDX_TERM_SEL) begin
			rdat = state_q.term;
		end else if (idx == `LEI_IDX_IEN_LINE) begin
			rdat = state_q.ien_line;
		end else if (idx == `LEI_IDX_IEN_ERR) begin
			rdat = state_q.ien_err;
		end else if (idx == `LEI_IDX_EDGE_SEL) begin
			rdat = state_q.edge_sel;
		end else if (idx == `LEI_IDX_LIVE_STAT) begin
			rdat = state_q.live;
		end else if (idx == `LEI_IDX_PEND_LINE) begin
			rdat = state_q.pend_line;
		end else if (idx == `LEI_IDX_PEND_ERR) begin
			rdat = state_q.pend_err;
		end else if (idx == `LEI_IDX_CNT_HIGH) begin
			rdat = state_q.cnt_snap[15:8];
		end else if (idx == `LEI_IDX_CNT_LOW) begin
			rdat = state_q.cnt_snap[7:0];
		end else begin
			rdat = 8'h00;
		end

		// Write decode; read-only and unmapped writes are dropped
		if (wr_en) begin
			if (idx == `LEI_IDX_MAINT_CTRL) begin
				wr_maint = 1'b1;
			end else if (idx == `LEI_IDX_TERM_SEL) begin
				wr_term = 1'b1;
			end else if (idx == `LEI_IDX_IEN_LINE) begin
				wr_ien_line = 1'b1;
			end else if (idx == `LEI_IDX_IEN_ERR) begin
				wr_ien_err = 1'b1;
			end else if (idx == `LEI_IDX_EDGE_SEL) begin
				wr_edge = 1'b1;
			end else if (idx == `LEI_IDX_PEND_LINE) begin
				wr_pend_line = 1'b1;
			end else if (idx == `LEI_IDX_PEND_ERR) begin
				wr_pend_err = 1'b1;
			end
		end

		// Masked writes to the control registers
		if (wr_maint) begin
			state_d.maint = lei_wr(state_q.maint, wbyte, `LEI_MASK_MAINT);
		end
		if (wr_term) begin
			state_d.term = lei_wr(state_q.term, wbyte, `LEI_MASK_TERM);
		end
		if (wr_ien_line) begin
			state_d.ien_line = lei_wr(state_q.ien_line, wbyte, `LEI_MASK_LINE);
		end
		if (wr_ien_err) begin
			state_d.ien_err = lei_wr(state_q.ien_err, wbyte, `LEI_MASK_ERR);
		end
		if (wr_edge) begin
			state_d.edge_sel = lei_wr(state_q.edge_sel, wbyte, `LEI_MASK_LINE);
		end

		// Write-one-to-clear masks for the pending flags
		clr_line = wr_pend_line ? (wbyte & `LEI_MASK_LINE) : 8'h00;
		clr_err = wr_pend_err ? (wbyte & `LEI_MASK_ERR) : 8'h00;

		// Wishbone handshake: ack one cycle after request, then drop
		case (state_q.bus)
			LEI_BUS_IDLE: begin
				if (req) begin
					state_d.bus = LEI_BUS_ACK;
					state_d.dat = {24'h000000, rdat};
				end
			end
			LEI_BUS_ACK: begin
				state_d.bus = LEI_BUS_IDLE;
				state_d.dat = 32'h00000000;
			end
			default: begin
				state_d.bus = LEI_BUS_IDLE;
			end
		endcase

		// Status change detection on the filtered live levels
		set_line = 8'h00;
		set_line[`LEI_BIT_DRV] = lei_edge_hit(state_q.live[`LEI_BIT_DRV], drv_new,
			state_q.edge_sel[`LEI_BIT_DRV]);
		set_line[`LEI_BIT_LOSS] = lei_edge_hit(state_q.live[`LEI_BIT_LOSS], loss_new,
			state_q.edge_sel[`LEI_BIT_LOSS]);

		// Event pulses into the error pending flags
		set_err = 8'h00;
		set_err[`LEI_BIT_TPL] = template_sum_evt_i;
		set_err[`LEI_BIT_TXJ] = tx_jitter_fifo_evt_i;
		set_err[`LEI_BIT_RXJ] = rx_jitter_fifo_evt_i;
		set_err[`LEI_BIT_EXZ] = excess_zero_evt_i;
		set_err[`LEI_BIT_BPV] = bipolar_violation_evt_i;
		set_err[`LEI_BIT_CNTOV] = counter_overflow_evt_i;

		// Sticky flags; a new event beats a same-cycle clear
		state_d.pend_line = lei_sticky(state_q.pend_line, set_line, clr_line);
		state_d.pend_err = lei_sticky(state_q.pend_err, set_err, clr_err);

		// Snapshot strobe edge, honoured in manual mode only
		snap_rise = !state_q.maint[`LEI_BIT_SNAP] && state_d.maint[`LEI_BIT_SNAP];

		// One-second report timer, runs only in auto mode
		sec_tick = 1'b0;
		if (state_q.maint[`LEI_BIT_MODE]) begin
			if (state_q.sec_cnt == SEC_LAST) begin
				state_d.sec_cnt = '0;
				sec_tick = 1'b1;
			end else begin
				state_d.sec_cnt = state_q.sec_cnt + `LEI_SEC_W'(1);
			end
		end else begin
			state_d.sec_cnt = '0;
		end

		// Copy the running count into the readable counter registers
		take_snap = state_q.maint[`LEI_BIT_MODE] ? sec_tick : snap_rise;
		if (take_snap) begin
			state_d.cnt_snap = excess_zero_count_i;
		end

		// Enabled pending flags onto the interrupt line
		en_line = 8'h00;
		en_line[`LEI_BIT_DRV] = state_d.pend_line[`LEI_BIT_DRV]
			&& state_q.ien_line[`LEI_BIT_DRV];
		en_line[`LEI_BIT_LOSS] = state_d.pend_line[`LEI_BIT_LOSS]
			&& state_q.ien_line[`LEI_BIT_LOSS];
		en_err = 8'h00;
		en_err[`LEI_BIT_TPL] = state_d.pend_err[`LEI_BIT_TPL]
			&& state_q.ien_err[`LEI_BIT_TPL];
		en_err[`LEI_BIT_TXJ] = state_d.pend_err[`LEI_BIT_TXJ]
			&& state_q.ien_err[`LEI_BIT_TXJ];
		en_err[`LEI_BIT_RXJ] = state_d.pend_err[`LEI_BIT_RXJ]
			&& state_q.ien_err[`LEI_BIT_RXJ];
		en_err[`LEI_BIT_EXZ] = state_d.pend_err[`LEI_BIT_EXZ]
			&& state_q.ien_err[`LEI_BIT_EXZ];
		en_err[`LEI_BIT_BPV] = state_d.pend_err[`LEI_BIT_BPV]
			&& state_q.ien_err[`LEI_BIT_BPV];
		en_err[`LEI_BIT_CNTOV] = state_d.pend_err[`LEI_BIT_CNTOV]
			&& state_q.ien_err[`LEI_BIT_CNTOV];
		state_d.irq = (|en_line) || (|en_err);

		// Termination decode; upper code bit flags reserved or bypass
		state_d.tx_code = lei_term_code(state_q.term[`LEI_TX_MSB:`LEI_TX_LSB]);
		state_d.tx_reserved = lei_term_upper(state_q.term[`LEI_TX_MSB:`LEI_TX_LSB]);
		state_d.rx_code = lei_term_code(state_q.term[`LEI_RX_MSB:`LEI_RX_LSB]);
		state_d.rx_bypass = lei_term_upper(state_q.term[`LEI_RX_MSB:`LEI_RX_LSB]);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q.bus <= LEI_BUS_IDLE;
			state_q.dat <= 32'h00000000;
			state_q.drv_sync <= 3'h0;
			state_q.loss_sync <= 3'h0;
			state_q.maint <= `LEI_RST_ZERO;
			state_q.term <= `LEI_RST_TERM;
			state_q.ien_line <= `LEI_RST_ZERO;
			state_q.ien_err <= `LEI_RST_ZERO;
			state_q.edge_sel <= `LEI_RST_ZERO;
			state_q.live <= `LEI_RST_ZERO;
			state_q.pend_line <= `LEI_RST_ZERO;
			state_q.pend_err <= `LEI_RST_ZERO;
			state_q.cnt_snap <= 16'h0000;
			state_q.sec_cnt <= '0;
			state_q.irq <= 1'b0;
			state_q.tx_code <= TERM_RST[`LEI_TX_LSB+1:`LEI_TX_LSB];
			state_q.tx_reserved <= TERM_RST[`LEI_TX_MSB];
			state_q.rx_code <= TERM_RST[`LEI_RX_LSB+1:`LEI_RX_LSB];
			state_q.rx_bypass <= TERM_RST[`LEI_RX_MSB];
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign dat_o = state_q.dat;
	assign ack_o = (state_q.bus == LEI_BUS_ACK);
	assign irq_o = state_q.irq;
	assign tx_term_code_o = state_q.tx_code;
	assign tx_term_reserved_o = state_q.tx_reserved;
	assign rx_term_code_o = state_q.rx_code;
	assign rx_term_bypass_o = state_q.rx_bypass;

endmodule : lei_line_event_ctrl

// ---- bench/lei_line_event_checker.sv ----
`timescale 1ns/100ps
module lei_line_event_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic irq_o,
	input wire logic [1:0] tx_term_code_o,
	input wire logic tx_term_reserved_o,
	input wire logic [1:0] rx_term_code_o,
	input wire logic rx_term_bypass_o
);
	logic term_wr;
	// Termination write taken at this edge
	assign term_wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i[11:2] == 10'h032;
	// All properties share the one clock
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_ack_single:
		assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	chk_ack_latency:
		assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack not one cycle after request");
	chk_dat_idle:
		assert property (!ack_o |-> dat_o == 32'h0) else $error("read data without ack");
	chk_dat_upper:
		assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("read data upper bits set");
	chk_tx_term:
		assert property (term_wr |-> ##2 {tx_term_reserved_o, tx_term_code_o} == $past(dat_i[5:3], 2)) else $error("tx code");
	chk_rx_term:
		assert property (term_wr |-> ##2 {rx_term_bypass_o, rx_term_code_o} == $past(dat_i[2:0], 2)) else $error("rx code");
	chk_term_hold:
		assert property (!$past(term_wr) && !$past(term_wr, 2) |-> $stable({tx_term_code_o, tx_term_reserved_o,
			rx_term_code_o, rx_term_bypass_o})) else $error("termination changed without write");
	chk_irq_release:
		assert property ($fell(irq_o) |-> $past(cyc_i && we_i) || $past(cyc_i && we_i, 2)) else $error("irq fell alone");
endmodule : lei_line_event_checker

bind lei_line_event_ctrl lei_line_event_checker lei_line_event_checker_inst (.*);

// ---- bench/lei_host_model.sv ----
`timescale 1ns/100ps
module lei_host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [11:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	logic [31:0] exp_q[$];
	// Bus idle at time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 12'h000;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end
	// One classic cycle, held until ack
	task automatic xfer(input logic [9:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= {a, 2'b00};
		sel_o <= 4'h1;
		dat_o <= {24'h0, d};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		dat_o <= ~dat_o; // No stale data once released
	endtask : xfer
endmodule : lei_host_model

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, driver_fault_i, signal_loss_i, tx_term_reserved_o;
	logic rx_term_bypass_o;
	logic [1:0] tx_term_code_o, rx_term_code_o;
	logic [11:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	logic [5:0] evt;
	logic [15:0] excess_zero_count_i, c1, c2;
	logic [7:0] m;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed = 32'h7c3d6fb2;
	int pos[6] = '{0, 1, 2, 4, 5, 6};
	wire [7:0] pins = {2'h0, rx_term_bypass_o, rx_term_code_o, tx_term_reserved_o, tx_term_code_o};
	wire [7:0] irq = {7'h0, irq_o};
	wire template_sum_evt_i = evt[5];
	wire tx_jitter_fifo_evt_i = evt[4];
	wire rx_jitter_fifo_evt_i = evt[3];
	wire excess_zero_evt_i = evt[2];
	wire bipolar_violation_evt_i = evt[1];
	wire counter_overflow_evt_i = evt[0];
	lei_line_event_ctrl #(.REPORT_CYCLES(20)) lei_line_event_ctrl_inst (.*);
	lei_host_model lei_host_model_inst (.clk_i(clk_i), .ack_i(ack_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
		.adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
	task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t read exp %h got %h", $time, e, g);
		end
	endtask : chk_rd
	task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t pin exp %h got %h", $time, e, g);
		end
	endtask : chk_pin
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		lei_host_model_inst.xfer(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		lei_host_model_inst.exp_q.push_back({24'h0, e});
		lei_host_model_inst.xfer(a, 1'b0, 8'h00);
	endtask : rd
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wait_n
	task automatic live(input int j, input logic v);
		@(posedge clk_i);
		if (j == 0) signal_loss_i <= v;
		else driver_fault_i <= v;
	endtask : live
	task automatic end_sim;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	// Clock and hang limit
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			end_sim();
		end
	end
	// Read answers against oldest note
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && lei_host_model_inst.exp_q.size() > 0) begin
			chk_rd(lei_host_model_inst.exp_q.pop_front(), dat_o);
		end
	end
	// Main sequence
	initial begin
		rst_i = 1'b1;
		driver_fault_i = 1'b0;
		signal_loss_i = 1'b0;
		evt = 6'h00;
		excess_zero_count_i = 16'h0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_n(1);
		chk_pin(pins, 8'h38);
		rd(10'h032, 8'h07);
		for (int a = 'h33; a <= 'h3d; a++) rd(10'(a), 8'h00);
		wr(10'h036, 8'hff);
		rd(10'h036, 8'h00);
		wr(10'h3ff, 8'hff);
		rd(10'h3ff, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			c1 = 16'($random(seed));
			wr(10'h032, {c1[7:6], i[2:0], 3'(7 - i)});
			wait_n(2);
			chk_pin(pins, {2'b00, 3'(7 - i), i[2:0]});
			rd(10'h032, {2'b00, i[2:0], 3'(7 - i)});
		end
		$display("test termination done");
		for (int k = 0; k < 6; k++) begin
			m = 8'(1 << pos[k]);
			@(posedge clk_i);
			evt[k] <= 1'b1;
			@(posedge clk_i);
			evt <= 6'h00;
			wait_n(1);
			chk_pin(irq, 8'h00);
			rd(10'h03b, m);
			wr(10'h034, m);
			wait_n(2);
			chk_pin(irq, 8'h01);
			wr(10'h03b, 8'h00);
			wait_n(1);
			chk_pin(irq, 8'h01);
			wr(10'h03b, m);
			wait_n(1);
			chk_pin(irq, 8'h00);
			wr(10'h034, 8'h00);
		end
		$display("test error events done");
		for (int j = 0; j <= 2; j += 2) begin
			m = 8'(1 << j);
			wr(10'h033, m);
			live(j, 1'b1);
			wait_n(8);
			rd(10'h036, m);
			rd(10'h03a, m);
			chk_pin(irq, 8'h01);
			wr(10'h03a, m);
			live(j, 1'b0);
			wait_n(8);
			rd(10'h036, 8'h00);
			rd(10'h03a, 8'h00);
			wr(10'h033, 8'h00);
			wr(10'h035, m);
			live(j, 1'b1);
			wait_n(8);
			wr(10'h03a, m);
			live(j, 1'b0);
			wait_n(8);
			rd(10'h03a, m);
			chk_pin(irq, 8'h00);
			wr(10'h03a, m);
			wr(10'h035, 8'h00);
		end
		$display("test line events done");
		c1 = 16'($random(seed));
		c2 = 16'($random(seed));
		@(posedge clk_i);
		excess_zero_count_i <= c1;
		wr(10'h031, 8'h01);
		rd(10'h03c, c1[15:8]);
		rd(10'h03d, c1[7:0]);
		@(posedge clk_i);
		excess_zero_count_i <= c2;
		wr(10'h031, 8'h01);
		rd(10'h03d, c1[7:0]);
		wr(10'h031, 8'h00);
		wr(10'h031, 8'h01);
		rd(10'h03c, c2[15:8]);
		rd(10'h03d, c2[7:0]);
		wr(10'h031, 8'h02);
		@(posedge clk_i);
		excess_zero_count_i <= c1;
		wr(10'h031, 8'h03);
		rd(10'h03d, c2[7:0]);
		wait_n(25);
		rd(10'h03c, c1[15:8]);
		rd(10'h03d, c1[7:0]);
		$display("test counter done");
		wait_n(2);
		end_sim();
	end
endmodule : testbench
